// ---- remote_switch_link_control_test.sv ----
// Purpose: directed bench for rsl_top, transmitter then receiver role
// Assumes: TICK_CYC of 4, so one millisecond is four cycles
// Notes:   outputs sampled on the falling edge, APB read data and error flag on the rising edge
`timescale 1ns/100ps
`default_nettype none
module remote_switch_link_control_test;
  localparam int T = 4;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic              role_receiver = 1'b0;
  logic [1:0]        mode_or_mapping_switch = 2'b00;
  logic [11:0]       unit_address_switch = 12'ha5c;
  logic [3:0]        channel_or_relay_mode_switch = 4'h0;
  logic              output_group_switch = 1'b1;
  logic [5:0]        off_delay_trimmer = 6'h00;
  logic [3:0]        contact_in_n = 4'hf;
  logic signed [7:0] rssi_dbm = 8'sh80;
  logic              send = 1'b0;
  logic [11:0]       pa = 12'h000;
  logic              pg = 1'b0;
  logic [3:0]        pi = 4'h0;
  logic [31:0]       prdata, rd;
  logic              pready, pslverr, tx_key, upper_channel, rx_burst_valid, rx_group, er, tg;
  logic [11:0]       tx_address, rx_address;
  logic [3:0]        tx_inputs, rx_inputs, relay_out;
  logic [5:0]        tx_interval_s, rx_interval_s;
  logic [17:0]       synth_freq_khz;
  logic [4:0]        rssi_led;
  logic [7:0]        dbv[6] = '{8'h9b, 8'h9c, 8'ha6, 8'hb0, 8'hb5, 8'hba};
  logic [4:0]        lv[6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
  logic [3:0]        bi[7] = '{4'h3, 4'h4, 4'h8, 4'h2, 4'h0, 4'h2, 4'h5};
  logic [3:0]        be[7] = '{4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h0, 4'h5};
  logic              bx[7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic              bg[7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  int                mismatches = 0;
  int                tests_run = 0;
  int                n;
  always #12.5 pclk = ~pclk;
  rsl_top #(.TICK_CYC(T)) DUT (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .role_receiver, .mode_or_mapping_switch, .unit_address_switch, .channel_or_relay_mode_switch,
    .output_group_switch, .off_delay_trimmer, .contact_in_n, .tx_key, .tx_address, .tx_inputs,
    .tx_group(tg), .tx_interval_s, .upper_channel, .synth_freq_khz, .rx_burst_valid, .rx_address,
    .rx_group, .rx_inputs, .rx_interval_s, .rssi_dbm, .relay_out, .rssi_led
  );
  rsl_partner P (
    .pclk, .send, .addr(pa), .grp(pg), .ins(pi), .intv(6'h02), .rx_burst_valid, .rx_address,
    .rx_group, .rx_inputs, .rx_interval_s
  );
  // ==========
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic wt(input int c);
    repeat (c) @(negedge pclk);
  endtask : wt
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic boot(input logic r, input logic [1:0] m, input logic [3:0] c);
    @(posedge pclk);
    presetn                      <= 1'b0;
    role_receiver                <= r;
    mode_or_mapping_switch       <= m;
    channel_or_relay_mode_switch <= c;
    unit_address_switch          <= 12'ha5c;
    contact_in_n                 <= 4'hf;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wt(3);
  endtask : boot
  // waits for the key level, cycle count left in n
  task automatic kw(input logic v);
    n = 0;
    while (tx_key !== v && n < 40000) begin
      @(negedge pclk);
      n++;
    end
  endtask : kw
  task automatic rng(input int lo, input int hi);
    check({31'd0, n >= lo && n <= hi}, 32'd1);
  endtask : rng
  task automatic burst(input logic [11:0] a, input logic g, input logic [3:0] i);
    @(posedge pclk);
    send <= 1'b1;
    pa   <= a;
    pg   <= g;
    pi   <= i;
    @(posedge pclk);
    send <= 1'b0;
    wt(3);
  endtask : burst
  // ==========
  // tests
  initial begin
    boot(1'b0, 2'b00, 4'h1);
    check(synth_freq_khz, 18'h25be8);
    @(posedge pclk) unit_address_switch <= 12'h3c3;
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h00041a5c);
    check(tx_address, 12'ha5c);
    check(tg, 1'b1);
    apb(1'b0, 12'h010, 32'h0);
    check(er, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, 12'h000, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h3);
    @(posedge pclk) contact_in_n <= 4'he;
    kw(1'b1);
    rng(70, 110);
    check(tx_inputs, 4'h1);
    wt(10000);
    check(tx_key, 1'b1);
    // intermittent mode, shortest off delay
    boot(1'b0, 2'b01, 4'h0);
    @(posedge pclk) contact_in_n <= 4'he;
    kw(1'b1);
    check(tx_interval_s, 6'h02);
    kw(1'b0);
    rng(5990, 6010);
    kw(1'b1);
    rng(7990, 8010);
    kw(1'b0);
    wt(1000);
    @(posedge pclk);
    off_delay_trimmer <= 6'h3f;
    contact_in_n      <= 4'hc;
    kw(1'b1);
    rng(70, 110);
    check(tx_inputs, 4'h3);
    check(tx_interval_s, 6'h3e);
    // receiver, relay 1 latching
    boot(1'b1, 2'b00, 4'h2);
    wt(400);
    check(synth_freq_khz, 18'h25bca);
    check(rssi_led, 5'h01);
    wt(800);
    check(rssi_led, 5'h02);
    wt(3200);
    for (int k = 0; k < 6; k++) begin
      @(posedge pclk) rssi_dbm <= dbv[k];
      wt(8);
      check(rssi_led, lv[k]);
    end
    apb(1'b1, 12'h000, 32'h3);
    wt(2);
    check(synth_freq_khz, 18'h25be8);
    for (int k = 0; k < 7; k++) begin
      burst(12'ha5c ^ {11'd0, bx[k]}, bg[k], bi[k]);
      check(relay_out, be[k]);
    end
    wt(3800);
    check(relay_out, 4'h5);
    wt(400);
    check(relay_out, 4'h0);
    boot(1'b1, 2'b10, 4'h0);
    burst(12'ha5c, 1'b0, 4'h9);
    wt(4400);
    check(relay_out, 4'h9);
    wt(12000);
    check(relay_out, 4'h0);
    summarize();
  end
  // sized for roughly 1.4 times the expected run
  initial begin
    repeat (80000) @(posedge pclk);
    mismatches++;
    summarize();
  end
endmodule : remote_switch_link_control_test
`default_nettype wire

// ---- rsl_cfg.svh ----
// Purpose: timing, offset and reset constants of the remote switch link control
// Assumes: 40 MHz pclk, millisecond time base derived from it
// Notes:   definitions only
`ifndef RSL_CFG_SVH
`define RSL_CFG_SVH

// ==========================================================================
// time base
`define RSL_CLK_NS          25
`define RSL_TICK_NS         1000000
`define RSL_MS_PER_S        19'h3e8

// ==========================================================================
// transmitter timing, in milliseconds or seconds
`define RSL_TX_LIMIT_MS     19'h493e0
`define RSL_BURST_MS        19'h5dc
`define RSL_OFF_MIN_S       6'h02
`define RSL_OFF_SPAN_S      6'h3c
`define RSL_DEBOUNCE_MS     5'h14

// ==========================================================================
// receiver timing
`define RSL_RX_TIMEOUT_MS   19'h3e8
`define RSL_HOLD_MARGIN_MS  19'h1f4
`define RSL_LED_STEP_MS     19'h0c8
`define RSL_LED_STEPS       3'h5
`define RSL_NCH             4

// ==========================================================================
// signal strength thresholds, signed dBm
`define RSL_RSSI_TH1        8'sh9c
`define RSL_RSSI_TH2        8'sha6
`define RSL_RSSI_TH3        8'shb0
`define RSL_RSSI_TH4        8'shb5
`define RSL_RSSI_TH5        8'shba

// ==========================================================================
// synthesiser settings in kHz
`define RSL_CH_LOWER_KHZ    18'h25bca
`define RSL_CH_UPPER_KHZ    18'h25be8

// ==========================================================================
// register map
`define RSL_REG_CTRL        12'h000
`define RSL_REG_STATUS      12'h004
`define RSL_REG_CONFIG      12'h008
`define RSL_REG_RSSI        12'h00c
`define RSL_CTRL_RST        2'h1
`define RSL_CTRL_EN         0
`define RSL_CTRL_RXUP       1

`endif

// ---- rsl_chk.sv ----
// Purpose: port-level assertions for rsl_top
// Assumes: straps are latched at the first edge after reset
// Notes:   enable bit is tracked from APB writes
`timescale 1ns/100ps
`default_nettype none
module rsl_chk #(
  parameter int TICK_CYC = 40000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        role_receiver,
  input wire logic [1:0]  mode_or_mapping_switch,
  input wire logic [11:0] unit_address_switch,
  input wire logic [3:0]  channel_or_relay_mode_switch,
  input wire logic [3:0]  contact_in_n,
  input wire logic        tx_key,
  input wire logic [3:0]  tx_inputs,
  input wire logic        upper_channel,
  input wire logic [17:0] synth_freq_khz,
  input wire logic        rx_burst_valid,
  input wire logic [11:0] rx_address,
  input wire logic        rx_group,
  input wire logic [3:0]  rx_inputs,
  input wire logic [3:0]  relay_out,
  input wire logic [4:0]  rssi_led
);
  // tick alignment slack of a few cycles
  localparam longint BUR = 64'd1500 * TICK_CYC + 10;
  localparam longint LIM = 64'd300000 * TICK_CYC + 10;
  logic        st_q, en_q, rl_q, gp_q;
  logic [11:0] ad_q;
  logic [3:0]  rm_q, ip_q;
  longint      kc_q, bc_q;
  // ==========
  // helper state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 1'b1;
      en_q <= 1'b1;
      rl_q <= 1'b0;
      gp_q <= 1'b0;
      ad_q <= 12'h000;
      rm_q <= 4'h0;
      ip_q <= 4'h0;
      kc_q <= 0;
      bc_q <= 0;
    end else begin
      if (st_q) begin
        rl_q <= role_receiver;
        gp_q <= mode_or_mapping_switch[0];
        ad_q <= unit_address_switch;
        rm_q <= channel_or_relay_mode_switch;
      end
      st_q <= 1'b0;
      if (psel && penable && pready && pwrite && paddr == 12'h000) en_q <= pwdata[0];
      kc_q <= tx_key ? kc_q + 1 : 0;
      bc_q <= (tx_key && tx_inputs == ip_q) ? bc_q + 1 : 0;
      ip_q <= tx_inputs;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_hit;
    rx_burst_valid && rl_q && en_q && !st_q && rx_address == ad_q && rx_group == gp_q;
  endsequence
  // ==========
  // assertions
  a_apb_ready: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h00c || paddr[1:0] != 2'h0))
    else $error("error flag wrong for address");
  a_freq_chan: assert property (synth_freq_khz == (upper_channel ? 18'h25be8 : 18'h25bca))
    else $error("frequency does not match channel");
  a_rx_silent: assert property (rl_q && !st_q |-> !tx_key)
    else $error("receiver keyed the transmitter");
  a_burst_refresh: assert property (s_hit |=> (relay_out & ~rm_q) == ($past(rx_inputs) & ~rm_q))
    else $error("momentary relays not refreshed");
  a_sweep_start: assert property ($rose(presetn) |-> ##[1:3] rssi_led == 5'h01)
    else $error("sweep did not start");
  a_debounce_hold: assert property ($changed(contact_in_n) && !rl_q |=> $stable(tx_inputs)[*8])
    else $error("input passed without debounce");
  a_change_keys: assert property ($changed(tx_inputs) && !rl_q && en_q |-> ##[0:2] tx_key)
    else $error("no update burst on change");
  a_burst_len: assert property (gp_q && !rl_q |-> bc_q <= BUR)
    else $error("burst too long");
  a_key_limit: assert property (kc_q <= LIM)
    else $error("transmission over limit");
endmodule : rsl_chk
bind rsl_top rsl_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .role_receiver, .mode_or_mapping_switch, .unit_address_switch, .channel_or_relay_mode_switch,
  .contact_in_n, .tx_key, .tx_inputs, .upper_channel, .synth_freq_khz, .rx_burst_valid,
  .rx_address, .rx_group, .rx_inputs, .relay_out, .rssi_led
);
`default_nettype wire

// ---- rsl_partner.sv ----
// Purpose: paired remote unit seen through its decoded bursts
// Assumes: send is a one-cycle request from the bench
// Notes:   idle fields toggle so stale data is never valid
`timescale 1ns/100ps
`default_nettype none
module rsl_partner (
  input  wire logic        pclk,
  input  wire logic        send,
  input  wire logic [11:0] addr,
  input  wire logic        grp,
  input  wire logic [3:0]  ins,
  input  wire logic [5:0]  intv,
  output var  logic        rx_burst_valid = 1'b0,
  output var  logic [11:0] rx_address = 12'h000,
  output var  logic        rx_group = 1'b0,
  output var  logic [3:0]  rx_inputs = 4'h0,
  output var  logic [5:0]  rx_interval_s = 6'h00
);
  always @(posedge pclk) begin
    rx_burst_valid <= send;
    rx_address     <= send ? addr : ~rx_address;
    rx_group       <= send ? grp : ~rx_group;
    rx_inputs      <= send ? ins : ~rx_inputs;
    rx_interval_s  <= send ? intv : ~rx_interval_s;
  end
endmodule : rsl_partner
`default_nettype wire

// ---- rsl_pkg.sv ----
// Purpose: types of the remote switch link control
// Assumes: constants come from rsl_cfg.svh
// Notes:   one state struct per module
`include "rsl_cfg.svh"

package rsl_pkg;

  // ==========================================================================
  // enumerations
  typedef enum logic [2:0] {TX_IDLE, TX_CONT, TX_LIMIT, TX_BURST, TX_OFFW} rsl_tx_state_t;

  // ==========================================================================
  // module state
  typedef struct packed {
    logic [`RSL_NCH-1:0] relay;
    logic [`RSL_NCH-1:0] prev;
    logic                armed;
    logic [18:0]         tmr;
    logic [18:0]         hold;
  } rsl_relay_st_t;

  typedef struct packed {
    logic [4:0]  led;
    logic        sweep;
    logic [2:0]  step;
    logic [18:0] tmr;
  } rsl_bar_st_t;

  typedef struct packed {
    logic [15:0]   tick_cnt;
    logic          tick;
    logic          cfg_done;
    logic          role_rx;
    logic [1:0]    sw_mode;
    logic [11:0]   addr;
    logic [3:0]    sw_chan;
    logic          group;
    logic [3:0]    raw;
    logic [3:0]    inputs;
    logic [4:0]    db_cnt;
    rsl_tx_state_t tx_st;
    logic [18:0]   tmr;
    logic [18:0]   lim;
    logic          tx_key;
    logic [5:0]    tx_interval;
    logic [17:0]   synth;
    logic          upper;
    logic [1:0]    ctrl;
    logic          pready;
    logic          pslverr;
    logic [31:0]   prdata;
  } rsl_top_st_t;

endpackage : rsl_pkg

// ---- rsl_relay.sv ----
// Purpose: receiver relay drive, momentary or latching, with hold timeout
// Assumes: burst is a one-cycle pulse for an accepted burst
// Notes:   tick is a one-cycle millisecond strobe
`timescale 1ns/100ps
`default_nettype none

module rsl_relay
  import rsl_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                tick,
  input  wire logic                burst,
  input  wire logic [`RSL_NCH-1:0] burst_inputs,
  input  wire logic [5:0]          burst_interval_s,
  input  wire logic [`RSL_NCH-1:0] latch_mode,
  input  wire logic                hold_extension,
  output var  logic [`RSL_NCH-1:0] relay
);

  rsl_relay_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (burst) begin
      // refresh at once, whatever the timeout stands at
      s_d.armed = 1'b1;
      s_d.tmr   = 19'h0;
      if (hold_extension && burst_interval_s != 6'h0) begin
        // stretch over the transmitter off delay so outputs stay steady
        s_d.hold = 19'(burst_interval_s) * `RSL_MS_PER_S + `RSL_BURST_MS + `RSL_HOLD_MARGIN_MS;
      end else begin
        s_d.hold = `RSL_RX_TIMEOUT_MS;
      end
      for (int i = 0; i < `RSL_NCH; i++) begin
        if (latch_mode[i]) begin
          s_d.relay[i] = s_q.relay[i] ^ (burst_inputs[i] & ~s_q.prev[i]);
        end else begin
          s_d.relay[i] = burst_inputs[i];
        end
      end
      s_d.prev = burst_inputs;
    end else if (s_q.armed && tick) begin
      s_d.tmr = s_q.tmr + 19'h1;
      if (s_d.tmr >= s_q.hold) begin
        // silence: momentary outputs drop, latched ones keep their state
        s_d.armed = 1'b0;
        s_d.relay = s_q.relay & latch_mode;
        s_d.prev  = '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign relay = s_q.relay;

endmodule : rsl_relay

`default_nettype wire

// ---- rsl_rssi_bar.sv ----
// Purpose: five-segment signal strength bar with power-up sweep
// Assumes: rssi_dbm is a signed dBm estimate from the radio
// Notes:   the sweep runs once after reset
`timescale 1ns/100ps
`default_nettype none

module rsl_rssi_bar
  import rsl_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              tick,
  input  wire logic signed [7:0] rssi_dbm,
  output var  logic [4:0]        led
);

  rsl_bar_st_t s_q, s_d;

  function automatic logic [4:0] bar(input logic signed [7:0] dbm);
    bar = {dbm >= `RSL_RSSI_TH5, dbm >= `RSL_RSSI_TH4, dbm >= `RSL_RSSI_TH3,
           dbm >= `RSL_RSSI_TH2, dbm >= `RSL_RSSI_TH1};
  endfunction : bar

  always_comb begin
    s_d = s_q;
    if (s_q.sweep) begin
      s_d.led = 5'h1 << s_q.step;
      if (tick) begin
        s_d.tmr = s_q.tmr + 19'h1;
        if (s_d.tmr >= `RSL_LED_STEP_MS) begin
          s_d.tmr  = 19'h0;
          s_d.step = s_q.step + 3'h1;
          if (s_d.step == `RSL_LED_STEPS) begin
            s_d.sweep = 1'b0;
          end
        end
      end
    end else begin
      s_d.led = bar(rssi_dbm);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.sweep <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign led = s_q.led;

endmodule : rsl_rssi_bar

`default_nettype wire

// ---- rsl_top.sv ----
// Purpose: remote switch link control, transmitter scheduling and receiver outputs
// Assumes: one pclk domain, inputs synchronous, switches settle before reset release
// Notes:   role strap picks transmitter or receiver behaviour
//
// Function
// - input change sends an extra update burst, except in continuous mode while an input stays active
// - mode off: transmit while any input active
// - continuous transmission capped at five minutes
// - mode on: 1.5 s burst, then off delay
// - off delay 2 to 62 s from trimmer
// - change during off delay transmits at once
// - intermittent cycle repeats while input active
// - 12-bit unit address from switch bank
// - channel switch picks lower or upper channel in transmitter role; receiver takes control register bit 1
// - receiver acts only on matching address
// - mapping bit selects outputs group; must match
// - per-relay mode bit, momentary or latching
// - momentary relay follows reported input
// - latching relay toggles per new activation
// - hold extension stretches hold to interval
// - hold extension gives steady outputs
// - every valid burst refreshes outputs at once
// - configuration switches latched at power-up
// - five-segment strength bar at set thresholds
// - power-up display sweep on bar
`timescale 1ns/100ps
`default_nettype none

module rsl_top
  import rsl_pkg::*;
#(
  parameter int TICK_CYC = `RSL_TICK_NS / `RSL_CLK_NS
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [11:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic              role_receiver,
  input  wire logic [1:0]        mode_or_mapping_switch,
  input  wire logic [11:0]       unit_address_switch,
  input  wire logic [3:0]        channel_or_relay_mode_switch,
  input  wire logic              output_group_switch,
  input  wire logic [5:0]        off_delay_trimmer,
  input  wire logic [3:0]        contact_in_n,
  output var  logic              tx_key,
  output var  logic [11:0]       tx_address,
  output var  logic [3:0]        tx_inputs,
  output var  logic              tx_group,
  output var  logic [5:0]        tx_interval_s,
  output var  logic              upper_channel,
  output var  logic [17:0]       synth_freq_khz,
  input  wire logic              rx_burst_valid,
  input  wire logic [11:0]       rx_address,
  input  wire logic              rx_group,
  input  wire logic [3:0]        rx_inputs,
  input  wire logic [5:0]        rx_interval_s,
  input  wire logic signed [7:0] rssi_dbm,
  output var  logic [3:0]        relay_out,
  output var  logic [4:0]        rssi_led
);

  // ==========================================================================
  // state
  rsl_top_st_t s_q, s_d;
  logic        rx_match;
  logic        hold_ext;
  logic        enable;

  // off delay in seconds; trimmer positions past the span clamp to the top
  function automatic logic [5:0] off_delay_s(input logic [5:0] trim);
    off_delay_s = `RSL_OFF_MIN_S + ((trim > `RSL_OFF_SPAN_S) ? `RSL_OFF_SPAN_S : trim);
  endfunction : off_delay_s

  function automatic logic [18:0] s_to_ms(input logic [5:0] sec);
    s_to_ms = 19'(sec) * `RSL_MS_PER_S;
  endfunction : s_to_ms

  assign enable   = s_q.ctrl[`RSL_CTRL_EN];
  assign hold_ext = s_q.sw_mode[1];
  // address and group compare against the power-up snapshot
  assign rx_match = rx_burst_valid && s_q.cfg_done && s_q.role_rx && enable
                    && rx_address == s_q.addr
                    && rx_group == s_q.sw_mode[0];

  // ==========================================================================
  // next state
  always_comb begin
    logic       change;
    logic       active;
    logic       tx_run;
    logic       mode_int;
    logic [5:0] off_s;
    change   = 1'b0;
    active   = 1'b0;
    tx_run   = 1'b0;
    mode_int = 1'b0;
    off_s    = 6'h0;
    s_d      = s_q;

    // millisecond strobe
    if (s_q.tick_cnt == 16'(TICK_CYC - 1)) begin
      s_d.tick_cnt = 16'h0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h1;
      s_d.tick     = 1'b0;
    end

    // switches are read once, on the first clock after reset release
    if (!s_q.cfg_done) begin
      s_d.cfg_done = 1'b1;
      s_d.role_rx  = role_receiver;
      s_d.sw_mode  = mode_or_mapping_switch;
      s_d.addr     = unit_address_switch;
      s_d.sw_chan  = channel_or_relay_mode_switch;
      s_d.group    = output_group_switch;
    end

    // debounce: raw level must hold still before it counts
    s_d.raw = ~contact_in_n;
    if (s_d.raw != s_q.raw) begin
      s_d.db_cnt = 5'h0;
    end else if (s_q.tick && s_q.db_cnt != `RSL_DEBOUNCE_MS) begin
      s_d.db_cnt = s_q.db_cnt + 5'h1;
    end
    if (s_q.db_cnt == `RSL_DEBOUNCE_MS && s_q.raw != s_q.inputs) begin
      s_d.inputs = s_q.raw;
      change     = 1'b1;
    end
    active   = |s_d.inputs;
    tx_run   = s_q.cfg_done && !s_q.role_rx && enable;
    mode_int = s_q.sw_mode[0];
    off_s    = off_delay_s(off_delay_trimmer);

    // ========================================================================
    // transmit scheduler
    if (s_q.tick) begin
      s_d.tmr = s_q.tmr + 19'h1;
    end
    if (!tx_run) begin
      s_d.tx_st = TX_IDLE;
    end else begin
      case (s_q.tx_st)
        TX_IDLE: begin
          if (change) begin
            s_d.tx_st = TX_BURST;
            s_d.tmr   = 19'h0;
          end else if (active && !mode_int) begin
            s_d.tx_st = TX_CONT;
            s_d.lim   = 19'h0;
          end
        end
        TX_CONT: begin
          if (s_q.tick) begin
            s_d.lim = s_q.lim + 19'h1;
          end
          if (s_d.lim >= `RSL_TX_LIMIT_MS) begin
            s_d.tx_st = TX_LIMIT;
          end else if (change && !active) begin
            // last input released: tell the receiver with an update burst
            s_d.tx_st = TX_BURST;
            s_d.tmr   = 19'h0;
          end else if (!active) begin
            s_d.tx_st = TX_IDLE;
          end
        end
        TX_LIMIT: begin
          // stays silent until the inputs move
          if (change) begin
            s_d.tx_st = TX_BURST;
            s_d.tmr   = 19'h0;
          end
        end
        TX_BURST: begin
          if (change) begin
            s_d.tmr = 19'h0;
          end else if (s_q.tmr >= `RSL_BURST_MS) begin
            s_d.tmr = 19'h0;
            if (active && mode_int) begin
              s_d.tx_st = TX_OFFW;
            end else if (active) begin
              s_d.tx_st = TX_CONT;
              s_d.lim   = s_q.tmr;
            end else begin
              s_d.tx_st = TX_IDLE;
            end
          end
        end
        TX_OFFW: begin
          if (change) begin
            s_d.tx_st = TX_BURST;
            s_d.tmr   = 19'h0;
          end else if (s_q.tmr >= s_to_ms(off_s)) begin
            s_d.tmr   = 19'h0;
            s_d.tx_st = active ? TX_BURST : TX_IDLE;
          end
        end
        default: begin
          s_d.tx_st = TX_IDLE;
        end
      endcase
    end
    s_d.tx_key = s_d.tx_st == TX_CONT || s_d.tx_st == TX_BURST;
    // intermittent bursts carry the off delay for the receiver hold
    s_d.tx_interval = mode_int ? off_s : 6'h0;

    // ========================================================================
    // channel
    s_d.upper = s_q.role_rx ? s_q.ctrl[`RSL_CTRL_RXUP] : s_q.sw_chan[0];
    s_d.synth = s_d.upper ? `RSL_CH_UPPER_KHZ : `RSL_CH_LOWER_KHZ;

    // ========================================================================
    // apb slave: answer one cycle after setup, no wait states
    s_d.pready  = psel && !penable;
    s_d.pslverr = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        `RSL_REG_CTRL:   s_d.prdata = {30'h0, s_q.ctrl};
        `RSL_REG_STATUS: s_d.prdata = {14'h0, s_q.cfg_done, rssi_led, relay_out, s_q.tx_st, s_q.tx_key,
                                       s_q.inputs};
        `RSL_REG_CONFIG: s_d.prdata = {12'h0, s_q.role_rx, s_q.group, s_q.sw_mode, s_q.sw_chan, s_q.addr};
        `RSL_REG_RSSI:   s_d.prdata = {24'h0, rssi_dbm};
        default: begin
          s_d.prdata  = 32'h0;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s_q.pready && pwrite && paddr == `RSL_REG_CTRL) begin
      s_d.ctrl = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.tx_st <= TX_IDLE;
      s_q.ctrl  <= `RSL_CTRL_RST;
      s_q.synth <= `RSL_CH_LOWER_KHZ;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // receiver outputs
  // hold extension assumes an intermittent sender and all relays momentary
  rsl_relay u_relay (
    .pclk             (pclk),
    .presetn          (presetn),
    .tick             (s_q.tick),
    .burst            (rx_match),
    .burst_inputs     (rx_inputs),
    .burst_interval_s (rx_interval_s),
    .latch_mode       (s_q.sw_chan),
    .hold_extension   (hold_ext),
    .relay            (relay_out)
  );

  rsl_rssi_bar u_bar (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (s_q.tick),
    .rssi_dbm (rssi_dbm),
    .led      (rssi_led)
  );

  // ==========================================================================
  // outputs straight from state
  assign prdata         = s_q.prdata;
  assign pready         = s_q.pready;
  assign pslverr        = s_q.pslverr;
  assign tx_key         = s_q.tx_key;
  assign tx_address     = s_q.addr;
  assign tx_inputs      = s_q.inputs;
  assign tx_group       = s_q.group;
  assign tx_interval_s  = s_q.tx_interval;
  assign upper_channel  = s_q.upper;
  assign synth_freq_khz = s_q.synth;

endmodule : rsl_top

`default_nettype wire
